// ---- ues_consts.svh ----
`ifndef UES_CONSTS_SVH
`define UES_CONSTS_SVH

`define UES_ADDR_W        12
`define UES_DATA_W        32
`define UES_OFF_ENABLE    12'h000
`define UES_OFF_STATUS    12'h004
`define UES_OFF_EPSTAT    12'h00C
`define UES_OFF_BUSATTR   12'h010
`define UES_WORD_LSB      2

`define UES_BIT_SETUP     31
`define UES_BIT_EP0       16
`define UES_EP_COUNT      3
`define UES_BIT_WAKE      3
`define UES_BIT_VBUS      2
`define UES_BIT_XACT      1
`define UES_BIT_BUSEV     0
`define UES_IRQ_BITS      4

`define UES_KIND_W        3
`define UES_KIND_LSB      8
`define UES_ATTR_W        4

`define UES_RST_WORD      32'h0000_0000
`define UES_RST_KIND      3'h0
`define UES_RST_ATTR      4'h0
`define UES_RST_EN        4'h0
`define UES_RESP_OKAY     2'h0
`define UES_RESP_SLVERR   2'h2

`endif

// ---- ues_pkg.sv ----
`include "ues_consts.svh"
package ues_pkg;
    typedef logic [`UES_KIND_W-1:0] ues_kind_t;
    typedef logic [`UES_ATTR_W-1:0] ues_attr_t;
    typedef enum logic {
        UES_WR_IDLE,
        UES_WR_RESP
    } ues_wr_state_t;
endpackage : ues_pkg

// ---- ues_reg_if.sv ----
`timescale 1ns/1ns
`include "ues_consts.svh"
interface ues_reg_if;
    logic                   wr_en;
    logic [`UES_ADDR_W-1:0] wr_addr;
    logic [`UES_DATA_W-1:0] wr_data;
    logic [3:0]             wr_strb;
    logic                   wr_err;
    logic [`UES_ADDR_W-1:0] rd_addr;
    logic [`UES_DATA_W-1:0] rd_data;
    logic                   rd_err;

    modport bus_side (
        output wr_en,
        output wr_addr,
        output wr_data,
        output wr_strb,
        output rd_addr,
        input  wr_err,
        input  rd_data,
        input  rd_err
    );
    modport reg_side (
        input  wr_en,
        input  wr_addr,
        input  wr_data,
        input  wr_strb,
        input  rd_addr,
        output wr_err,
        output rd_data,
        output rd_err
    );
endinterface : ues_reg_if

// ---- ues_sync.sv ----
`timescale 1ns/1ns
module ues_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level_q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            // s1 feeds s2 only; a change counts once s2 and s3 agree
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[gi]    <= 1'b0;
                    s2_q[gi]    <= 1'b0;
                    s3_q[gi]    <= 1'b0;
                    level_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= pin[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        level_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate
endmodule : ues_sync

// ---- ues_axi_slave.sv ----
`timescale 1ns/1ns
`include "ues_consts.svh"
module ues_axi_slave
    import ues_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [`UES_ADDR_W-1:0] awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [`UES_DATA_W-1:0] wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [`UES_ADDR_W-1:0] araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [`UES_DATA_W-1:0]      rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    ues_reg_if.bus_side                 regs
);
    ues_wr_state_t          wr_state_q;
    logic                   aw_full_q;
    logic                   w_full_q;
    logic [`UES_ADDR_W-1:0] aw_addr_q;
    logic [`UES_DATA_W-1:0] w_data_q;
    logic [3:0]             w_strb_q;

    wire aw_take = awvalid & awready;
    wire w_take  = wvalid & wready;
    wire commit  = (wr_state_q == UES_WR_IDLE) & aw_full_q & w_full_q;
    wire b_done  = bvalid & bready;
    wire ar_take = arvalid & arready;
    wire r_done  = rvalid & rready;

    assign regs.wr_en   = commit;
    assign regs.wr_addr = aw_addr_q;
    assign regs.wr_data = w_data_q;
    assign regs.wr_strb = w_strb_q;
    assign regs.rd_addr = araddr;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            awready   <= 1'b1;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= awaddr;
            awready   <= 1'b0;
        end else if (b_done) begin
            aw_full_q <= 1'b0;
            awready   <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            wready   <= 1'b1;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            wready   <= 1'b0;
        end else if (b_done) begin
            w_full_q <= 1'b0;
            wready   <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_state_q <= UES_WR_IDLE;
            bvalid     <= 1'b0;
            bresp      <= `UES_RESP_OKAY;
        end else begin
            case (wr_state_q)
                UES_WR_IDLE: begin
                    if (commit) begin
                        wr_state_q <= UES_WR_RESP;
                        bvalid     <= 1'b1;
                        bresp      <= regs.wr_err ? `UES_RESP_SLVERR : `UES_RESP_OKAY;
                    end
                end
                UES_WR_RESP: begin
                    if (bready) begin
                        wr_state_q <= UES_WR_IDLE;
                        bvalid     <= 1'b0;
                    end
                end
                default: wr_state_q <= UES_WR_IDLE;
            endcase
        end
    end

    // read data captured at the address handshake, held until taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= `UES_RST_WORD;
            rresp   <= `UES_RESP_OKAY;
        end else if (ar_take) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= regs.rd_data;
            rresp   <= regs.rd_err ? `UES_RESP_SLVERR : `UES_RESP_OKAY;
        end else if (r_done) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule : ues_axi_slave

// ---- ues_event_status.sv ----
// What this block does
// RL1: endpoint 2 flag, kind in 16:14
// RL2: endpoint 1 flag, kind in 13:11
// RL3: endpoint 0 flag, kind in 10:8
// RL4: idle wake-up flag bit 3, write-one clears
// RL5: cable attach/detach flag bit 2, sticky
// RL6: any transaction event sets bit 1
// RL7: bit 1 clears by itself or group clear
// RL8: suspend/resume flag bit 0, attribute kept
// RL9: status bits 15 to 4 carry nothing
// RL10: setup flag bit 31, write-one clears
// RL11: interrupt only where enable bit is set
// RL12: reserved reads zero, zero writes ignored
// RL13: simultaneous event beats its clear
`timescale 1ns/1ns
`include "ues_consts.svh"
module ues_event_status
    import ues_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [`UES_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [`UES_DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [`UES_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [`UES_DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic [`UES_EP_COUNT-1:0] ep_event,
    input  wire logic [8:0]               ep_kind,
    input  wire logic                     setup_event,
    input  wire logic                     idle_wakeup_event,
    input  wire logic                     vbus_pin,
    input  wire logic                     bus_state_event,
    input  wire logic [`UES_ATTR_W-1:0]   bus_state_attr,
    output logic                          irq_q
);
    ues_reg_if regs ();

    ues_axi_slave u_axi (
        .clk     (clk),
        .rst_n   (rst_n),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .regs    (regs.bus_side)
    );

    // cable sense is a pin, so it is filtered first
    logic vbus_level;
    logic vbus_prev_q;

    ues_sync #(.W(1)) u_vbus_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pin     (vbus_pin),
        .level_q (vbus_level)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vbus_prev_q <= 1'b0;
        end else begin
            vbus_prev_q <= vbus_level;
        end
    end

    // either edge is one attach or detach event
    wire vbus_change = vbus_level ^ vbus_prev_q;

    // address decode
    wire [`UES_ADDR_W-1:0] wa = regs.wr_addr;
    wire [`UES_ADDR_W-1:0] ra = regs.rd_addr;

    wire wa_en   = (wa == `UES_OFF_ENABLE);
    wire wa_sts  = (wa == `UES_OFF_STATUS);
    wire wa_eps  = (wa == `UES_OFF_EPSTAT);
    wire wa_attr = (wa == `UES_OFF_BUSATTR);
    wire ra_en   = (ra == `UES_OFF_ENABLE);
    wire ra_sts  = (ra == `UES_OFF_STATUS);
    wire ra_eps  = (ra == `UES_OFF_EPSTAT);
    wire ra_attr = (ra == `UES_OFF_BUSATTR);

    // read-only words drop writes quietly
    assign regs.wr_err = ~(wa_en | wa_sts | wa_eps | wa_attr);
    assign regs.rd_err = ~(ra_en | ra_sts | ra_eps | ra_attr);

    wire [`UES_DATA_W-1:0] byte_mask = {{8{regs.wr_strb[3]}},
                                        {8{regs.wr_strb[2]}},
                                        {8{regs.wr_strb[1]}},
                                        {8{regs.wr_strb[0]}}};

    wire                   sts_wr  = regs.wr_en & wa_sts;
    wire                   en_wr   = regs.wr_en & wa_en & regs.wr_strb[0];
    // only ones written through enabled lanes clear anything
    wire [`UES_DATA_W-1:0] w1c     = sts_wr ? (regs.wr_data & byte_mask) : `UES_RST_WORD; // RL12
    wire [`UES_DATA_W-1:0] en_bits = regs.wr_data & byte_mask;

    // interrupt enables
    logic [`UES_IRQ_BITS-1:0] enable_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= `UES_RST_EN;
        end else if (en_wr) begin
            enable_q <= en_bits[`UES_IRQ_BITS-1:0];
        end
    end

    // endpoint flags and their event kinds
    logic      [`UES_EP_COUNT-1:0] ep_flag_q;
    logic      [`UES_EP_COUNT-1:0] ep_flag_d;
    ues_kind_t                     ep_kind_q [`UES_EP_COUNT];
    wire                           xact_clr_req = w1c[`UES_BIT_XACT];

    genvar gi;
    generate
        for (gi = 0; gi < `UES_EP_COUNT; gi++) begin : g_ep
            wire ep_clr = w1c[`UES_BIT_EP0 + gi] | xact_clr_req; // RL1 RL2 RL3

            // set term wins over a same-cycle clear
            assign ep_flag_d[gi] = ep_event[gi] | (ep_flag_q[gi] & ~ep_clr); // RL13

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ep_flag_q[gi] <= 1'b0;
                    ep_kind_q[gi] <= `UES_RST_KIND;
                end else begin
                    ep_flag_q[gi] <= ep_flag_d[gi];
                    if (ep_event[gi]) begin
                        ep_kind_q[gi] <= ep_kind[gi*`UES_KIND_W +: `UES_KIND_W]; // RL1 RL2 RL3
                    end
                end
            end
        end
    endgenerate

    // setup, transaction, wake-up, cable and bus-state flags
    logic      setup_flag_q;
    logic      transaction_event_flag_q;
    logic      idle_wakeup_flag_q;
    logic      cable_attach_flag_q;
    logic      bus_state_event_flag_q;
    ues_attr_t bus_attr_q;

    wire setup_flag_d = setup_event | (setup_flag_q & ~w1c[`UES_BIT_SETUP]); // RL10 RL13

    // group clear drops bit 1 only once the whole group is empty
    wire group_hit   = w1c[`UES_BIT_SETUP] |
                       (|w1c[`UES_BIT_EP0 +: `UES_EP_COUNT]);
    wire group_empty = ~(|ep_flag_d) & ~setup_flag_d;
    wire xact_clr    = xact_clr_req | (group_hit & group_empty); // RL7
    wire xact_set    = (|ep_event) | setup_event; // RL6

    wire xact_d  = xact_set | (transaction_event_flag_q & ~xact_clr); // RL13
    wire wake_d  = idle_wakeup_event |
                   (idle_wakeup_flag_q & ~w1c[`UES_BIT_WAKE]); // RL4
    wire cable_d = vbus_change |
                   (cable_attach_flag_q & ~w1c[`UES_BIT_VBUS]); // RL5
    wire busev_d = bus_state_event |
                   (bus_state_event_flag_q & ~w1c[`UES_BIT_BUSEV]); // RL8

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_flag_q             <= 1'b0;
            transaction_event_flag_q <= 1'b0;
            idle_wakeup_flag_q       <= 1'b0;
            cable_attach_flag_q      <= 1'b0;
            bus_state_event_flag_q   <= 1'b0;
        end else begin
            setup_flag_q             <= setup_flag_d;
            transaction_event_flag_q <= xact_d;
            idle_wakeup_flag_q       <= wake_d;
            cable_attach_flag_q      <= cable_d;
            bus_state_event_flag_q   <= busev_d;
        end
    end

    // attribute of the last bus event, suspend or resume
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_attr_q <= `UES_RST_ATTR;
        end else if (bus_state_event) begin
            bus_attr_q <= bus_state_attr; // RL8
        end
    end

    // endpoint and setup events reach irq through bit 1
    wire [`UES_IRQ_BITS-1:0] irq_src = {idle_wakeup_flag_q,
                                        cable_attach_flag_q,
                                        transaction_event_flag_q,
                                        bus_state_event_flag_q};
    wire                     irq_d   = |(irq_src & enable_q); // RL11

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // read mux
    logic [`UES_DATA_W-1:0] sts_word;
    logic [`UES_DATA_W-1:0] eps_word;
    logic [`UES_DATA_W-1:0] en_word;
    logic [`UES_DATA_W-1:0] attr_word;

    always_comb begin
        sts_word = `UES_RST_WORD; // RL9 RL12
        sts_word[`UES_BIT_SETUP] = setup_flag_q;
        sts_word[`UES_BIT_EP0 +: `UES_EP_COUNT] = ep_flag_q;
        sts_word[`UES_BIT_WAKE]  = idle_wakeup_flag_q;
        sts_word[`UES_BIT_VBUS]  = cable_attach_flag_q;
        sts_word[`UES_BIT_XACT]  = transaction_event_flag_q;
        sts_word[`UES_BIT_BUSEV] = bus_state_event_flag_q;
    end

    always_comb begin
        eps_word = `UES_RST_WORD;
        for (int i = 0; i < `UES_EP_COUNT; i++) begin
            eps_word[`UES_KIND_LSB + i*`UES_KIND_W +: `UES_KIND_W] = ep_kind_q[i];
        end
    end

    always_comb begin
        en_word = `UES_RST_WORD;
        en_word[`UES_IRQ_BITS-1:0] = enable_q;
        attr_word = `UES_RST_WORD;
        attr_word[`UES_ATTR_W-1:0] = bus_attr_q;
    end

    assign regs.rd_data = ra_sts  ? sts_word  :
                          ra_eps  ? eps_word  :
                          ra_en   ? en_word   :
                          ra_attr ? attr_word : `UES_RST_WORD;
endmodule : ues_event_status

// ---- ues_host_model.sv ----
`timescale 1ns/1ns
`include "ues_consts.svh"
module ues_host_model (
    input  wire logic                clk,
    output logic [`UES_EP_COUNT-1:0] ep_event,
    output logic [8:0]               ep_kind,
    output logic                     setup_event,
    output logic                     idle_wakeup_event,
    output logic                     vbus_pin,
    output logic                     bus_state_event,
    output logic [`UES_ATTR_W-1:0]   bus_state_attr
);
    initial begin
        ep_event = '0;
        ep_kind = '0;
        setup_event = 1'b0;
        idle_wakeup_event = 1'b0;
        vbus_pin = 1'b0;
        bus_state_event = 1'b0;
        bus_state_attr = '0;
    end

    // one event per call; sel 6 flips the cable level instead of pulsing
    task automatic fire(input int sel, input logic [3:0] k);
        case (sel)
            0, 1, 2: begin
                ep_event[sel] <= 1'b1;
                ep_kind[3*sel +: 3] <= k[2:0];
            end
            3: setup_event <= 1'b1;
            4: idle_wakeup_event <= 1'b1;
            5: begin
                bus_state_event <= 1'b1;
                bus_state_attr <= k;
            end
            default: vbus_pin <= ~vbus_pin;
        endcase
        @(posedge clk);
        ep_event <= '0;
        setup_event <= 1'b0;
        idle_wakeup_event <= 1'b0;
        bus_state_event <= 1'b0;
        // qualifiers are not held past their pulse, so show garbage
        ep_kind <= ~ep_kind;
        bus_state_attr <= ~bus_state_attr;
        @(posedge clk);
    endtask : fire
endmodule : ues_host_model

// ---- ues_event_status_props.sv ----
`timescale 1ns/1ns
`include "ues_consts.svh"
module ues_event_status_props (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [`UES_ADDR_W-1:0] s_axi_araddr,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [`UES_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic                   irq_q
);
    logic [`UES_ADDR_W-1:0] rd_addr_q;
    wire                    ar_take = s_axi_arvalid && s_axi_arready;
    wire                    w_take = s_axi_awvalid && s_axi_awready
                                     && s_axi_wvalid && s_axi_wready;
    wire                    mapped = rd_addr_q inside {`UES_OFF_ENABLE, `UES_OFF_STATUS,
                                                       `UES_OFF_EPSTAT, `UES_OFF_BUSATTR};

    // address of the read in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_addr_q <= '0;
        end else if (ar_take) begin
            rd_addr_q <= s_axi_araddr;
        end
    end

    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_write_answer: assert property (w_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (ar_take |=> s_axi_rvalid)
        else $error("read data late");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
        else $error("write channel not freed");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not freed");
    a_write_refused: assert property (w_take |=> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_reserved_zero: assert property (
        s_axi_rvalid && rd_addr_q == `UES_OFF_STATUS
        |-> s_axi_rdata[15:4] == 12'h000 && s_axi_rdata[30:19] == 12'h000)
        else $error("reserved status bits set");
    a_unmapped_err: assert property (s_axi_rvalid && !mapped
        |-> s_axi_rresp == `UES_RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (s_axi_rvalid && mapped |-> s_axi_rresp == `UES_RESP_OKAY)
        else $error("mapped read refused");

    c_write: cover property (w_take);
    c_read: cover property (ar_take);
    c_irq: cover property ($rose(irq_q));
endmodule : ues_event_status_props

// ---- tb_usb_device_event_status.sv ----
`timescale 1ns/1ns
`include "ues_consts.svh"
module tb_usb_device_event_status;
    typedef struct packed {
        logic [2:0]  sel;
        logic [3:0]  kind;
        logic [3:0]  en;
        logic [31:0] stat;
        logic [11:0] aux;
        logic [31:0] auxv;
        logic        irq;
    } ues_row_t;

    logic        clk;
    logic        rst_n;
    logic [11:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [11:0] s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [2:0]  ep_event;
    logic [8:0]  ep_kind;
    logic        setup_event;
    logic        idle_wakeup_event;
    logic        vbus_pin;
    logic        bus_state_event;
    logic [3:0]  bus_state_attr;
    logic        irq_q;
    logic [1:0]  rsp;
    int          err_total;
    int          samples_checked;
    logic [11:0] regs [4] = '{`UES_OFF_ENABLE, `UES_OFF_STATUS,
                              `UES_OFF_EPSTAT, `UES_OFF_BUSATTR};
    // kind word is never cleared, so kinds build up over rows
    ues_row_t    rows [8] = '{
        '{3'h0, 4'h3, 4'h2, 32'h0001_0002, `UES_OFF_EPSTAT, 32'h0000_0300, 1'b1},
        '{3'h1, 4'h6, 4'h0, 32'h0002_0002, `UES_OFF_EPSTAT, 32'h0000_3300, 1'b0},
        '{3'h2, 4'h7, 4'h2, 32'h0004_0002, `UES_OFF_EPSTAT, 32'h0001_f300, 1'b1},
        '{3'h3, 4'h0, 4'h2, 32'h8000_0002, `UES_OFF_ENABLE, 32'h0000_0002, 1'b1},
        '{3'h4, 4'h0, 4'h8, 32'h0000_0008, `UES_OFF_ENABLE, 32'h0000_0008, 1'b1},
        '{3'h5, 4'h5, 4'h1, 32'h0000_0001, `UES_OFF_BUSATTR, 32'h0000_0005, 1'b1},
        '{3'h5, 4'ha, 4'he, 32'h0000_0001, `UES_OFF_BUSATTR, 32'h0000_000a, 1'b0},
        '{3'h6, 4'h0, 4'h4, 32'h0000_0004, `UES_OFF_ENABLE, 32'h0000_0004, 1'b1}};

    ues_event_status dut (.*);
    ues_host_model host (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        if (err_total == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // trailing edge: next call never retouches bready in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 99) begin
            err_total++;
            test_done();
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 99) begin
            err_total++;
            test_done();
        end
        rsp = s_axi_rresp;
        chk(s_axi_rdata, e);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : rchk

    initial begin
        err_total = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(`UES_OFF_STATUS, 32'hffff_ffff);
            wr(`UES_OFF_ENABLE, {28'h000_0000, rows[i].en});
            host.fire(rows[i].sel, rows[i].kind);
            repeat (8) @(posedge clk);
            rchk(`UES_OFF_STATUS, rows[i].stat);
            chk({31'h0, irq_q}, {31'h0, rows[i].irq});
            rchk(rows[i].aux, rows[i].auxv);
        end
        wr(`UES_OFF_STATUS, 32'hffff_ffff);
        host.fire(1, 4'h0);
        host.fire(2, 4'h0);
        wr(`UES_OFF_STATUS, 32'h0002_0000);
        rchk(`UES_OFF_STATUS, 32'h0004_0002);
        wr(`UES_OFF_STATUS, 32'h0004_0000);
        rchk(`UES_OFF_STATUS, 32'h0000_0000);
        host.fire(0, 4'h0);
        host.fire(3, 4'h0);
        wr(`UES_OFF_STATUS, 32'h0000_0002);
        rchk(`UES_OFF_STATUS, 32'h8000_0000);
        wr(`UES_OFF_STATUS, 32'h8000_0000);
        rchk(`UES_OFF_STATUS, 32'h0000_0000);
        host.fire(4, 4'h0);
        wr(`UES_OFF_STATUS, 32'h0000_0000);
        rchk(`UES_OFF_STATUS, 32'h0000_0008);
        s_axi_wstrb <= 4'he;
        wr(`UES_OFF_STATUS, 32'hffff_ffff);
        s_axi_wstrb <= 4'hf;
        rchk(`UES_OFF_STATUS, 32'h0000_0008);
        wr(`UES_OFF_EPSTAT, 32'hffff_ffff);
        chk({30'h0, rsp}, {30'h0, `UES_RESP_OKAY});
        rchk(`UES_OFF_EPSTAT, 32'h0000_0000);
        rchk(12'h020, 32'h0000_0000);
        chk({30'h0, rsp}, {30'h0, `UES_RESP_SLVERR});
        wr(12'h020, 32'h0000_0000);
        chk({30'h0, rsp}, {30'h0, `UES_RESP_SLVERR});
        wr(`UES_OFF_STATUS, 32'h0000_0008);
        rchk(`UES_OFF_STATUS, 32'h0000_0000);
        // second pulse meets the clear's commit cycle
        host.fire(5, 4'h3);
        fork
            wr(`UES_OFF_STATUS, 32'h0000_0001);
            begin
                @(posedge clk);
                host.fire(5, 4'h3);
            end
        join
        rchk(`UES_OFF_STATUS, 32'h0000_0001);
        // cable low again, else reset release sees an attach
        host.fire(6, 4'h0);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) rchk(regs[i], 32'h0000_0000);
        chk({31'h0, irq_q}, 32'h0000_0000);
        test_done();
    end
endmodule : tb_usb_device_event_status

bind ues_event_status ues_event_status_props u_props (.*);
